// ### core/acs_pkg.sv
// Shared constants for the converter sequencer
package acs_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CONTROL_A_REG = 8'h00;
  localparam logic [7:0] ADDR_CONTROL_B_REG = 8'h04;
  localparam logic [7:0] ADDR_CONTROL_C_REG = 8'h08;
  localparam logic [7:0] ADDR_CHAN = 8'h0C;
  localparam logic [7:0] ADDR_CMD = 8'h10;
  localparam logic [7:0] ADDR_EVENT_CONTROL_REG = 8'h14;
  localparam logic [7:0] ADDR_IRQEN = 8'h18;
  localparam logic [7:0] ADDR_IRQFLAG = 8'h1C;
  localparam logic [7:0] ADDR_RESULT = 8'h20;
  localparam logic [7:0] ADDR_WINLT = 8'h24;
  localparam logic [7:0] ADDR_WINHT = 8'h28;
  localparam logic [7:0] ADDR_WINCTRL = 8'h2C;
  localparam logic [7:0] ADDR_SAMPDLY = 8'h30;
  localparam logic [7:0] ADDR_STATUS = 8'h34;
  // Field positions
  localparam int EN_BIT = 0;
  localparam int FREE_RUNNING_SEL_BIT = 1;
  localparam int REF_LSB = 4;
  localparam int AUTO_BIT = 4;
  localparam int RDY_BIT = 0;
  localparam int WIN_BIT = 1;
  // Widths and limits
  localparam int DATA_W = 10;
  localparam int RES_W = 16;
  localparam int CHAN_W = 5;
  localparam int REF_W = 2;
  localparam logic [2:0] MAX_ACC_SEL = 3'h6;
  // Converter timing in converter-clock cycles
  localparam logic [3:0] CONV_CYCLES = 4'hD;
  localparam logic [3:0] SAMPLE_CYCLE = 4'h2;
  // Window comparator modes
  localparam logic [2:0] WIN_NONE = 3'h0;
  localparam logic [2:0] WIN_BELOW = 3'h1;
  localparam logic [2:0] WIN_ABOVE = 3'h2;
  localparam logic [2:0] WIN_INSIDE = 3'h3;
  localparam logic [2:0] WIN_OUTSIDE = 3'h4;
  // Reset values
  localparam logic [7:0] LFSR_SEED = 8'hA5;
  typedef enum logic [1:0] {ST_IDLE, ST_GAP, ST_CONV} acs_state_t;
endpackage

// ### core/acs_prescaler.sv
// Converter clock prescaler, held at zero while not running
`timescale 1ns/1ps
module acs_prescaler
  import acs_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic run_i,
  input wire logic [2:0] div_sel_i,
  output logic tick_o,
  output logic adc_clk_o
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic [8:0] factor;
  logic [7:0] half_m1;
  logic [7:0] last;
  // Division factor is 2, 4, ... 256
  assign factor = 9'h002 << div_sel_i;
  assign half_m1 = factor[8:1] - 8'h01;
  assign last = factor[7:0] - 8'h01;
  // Rising converter edge is when the count enters the upper half
  assign tick_o = run_i && (cnt_q == half_m1);
  assign cnt_d = !run_i ? 8'h00 : ((cnt_q == last) ? 8'h00 : cnt_q + 8'h01);

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      cnt_q <= 8'h00;
      adc_clk_o <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d; // RL12 RL13
      adc_clk_o <= run_i && (cnt_d > half_m1);
    end
  end
endmodule // acs_prescaler

// ### core/acs_sequencer.sv
// Conversion sequencer with APB register file
// Behaviour
// (RL1) Enable bit starts the converter; clearing it stops everything.
// (RL2) Channel and reference reach the converter only while enabled.
// (RL3) Result is right-justified, 10-bit per sample.
// (RL4) Start bit begins a conversion, reads one while busy, clears in single mode.
// (RL5) Channel change mid-conversion waits until that conversion ends.
// (RL6) Result-ready flag sets when the single sample or whole burst ends.
// (RL7) Interrupt only when result-ready flag and its enable are both set; the window flag with its own enable also raises it.
// (RL8) Result-ready flag sets even with its interrupt disabled.
// (RL9) With event input enabled, each incoming event triggers a conversion.
// (RL10) Event input is edge detected and sets the start bit.
// (RL11) Free-running restarts right after each completion, flagging each one.
// (RL12) Prescaler divides by selected factor, counts only while enabled.
// (RL13) Prescaler held reset when idle; start on next converter rising edge.
// (RL14) Each conversion lasts 13 converter-clock cycles.
// (RL15) Sample-and-hold fires two converter cycles after start.
// (RL16) Result-ready clears on result read or writing one to it.
// (RL17) Accumulate 1 to 64 samples as selected.
// (RL18) Programmable gap between burst samples, optionally pseudo-random.
// (RL19) Window comparator restricts interrupt to below, above, inside, outside.
// (RL20) Free-running continues only while the start bit stays one.
// (RL21) Selections latch at start, free again near end of conversion.
// (RL22) Accumulated sum appears in result only after the last sample.
// (RL23) Window check is made on each completed result, sums included.
`timescale 1ns/1ps
module acs_sequencer
  import acs_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic event_i,
  input wire logic [DATA_W-1:0] adc_data_i,
  output logic adc_clk_o,
  output logic sample_o,
  output logic [CHAN_W-1:0] channel_o,
  output logic [REF_W-1:0] reference_o,
  output logic conv_busy_o,
  output logic irq_o
);
  function automatic logic win_check(input logic [2:0] mode, input logic [RES_W-1:0] v,
                                     input logic [RES_W-1:0] lo, input logic [RES_W-1:0] hi);
    logic r;
    r = 1'b0;
    case (mode)
      WIN_BELOW: r = v < lo;
      WIN_ABOVE: r = v > hi;
      WIN_INSIDE: r = (v >= lo) && (v <= hi);
      WIN_OUTSIDE: r = (v < lo) || (v > hi);
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  acs_state_t state_q;
  acs_state_t state_d;
  logic [1:0] control_a_reg_q;
  logic [2:0] accsel_q;
  logic [2:0] clock_divider_sel_q;
  logic [REF_W-1:0] ref_q;
  logic [CHAN_W-1:0] chan_q;
  logic cmd_q;
  logic cmd_d;
  logic evin_q;
  logic [1:0] irqen_q;
  logic [1:0] flag_q;
  logic [1:0] flag_d;
  logic [RES_W-1:0] result_q;
  logic [RES_W-1:0] winlt_q;
  logic [RES_W-1:0] winht_q;
  logic [2:0] winmode_q;
  logic [3:0] sdly_q;
  logic sdly_auto_q;
  logic [3:0] cyc_q;
  logic [6:0] smp_q;
  logic [RES_W-1:0] acc_q;
  logic [4:0] gap_q;
  logic [4:0] gap_d;
  logic [7:0] lfsr_q;
  logic ev_s1_q;
  logic ev_s2_q;
  logic ev_s3_q;
  logic pready_q;

  wire enable = control_a_reg_q[EN_BIT];
  wire free_running_sel = control_a_reg_q[FREE_RUNNING_SEL_BIT];
  wire xfer = psel_i && penable_i && pready_q;
  wire wr = xfer && pwrite_i;
  wire rd = xfer && !pwrite_i;
  wire hit_control_a_reg = paddr_i == ADDR_CONTROL_A_REG;
  wire hit_control_b_reg = paddr_i == ADDR_CONTROL_B_REG;
  wire hit_control_c_reg = paddr_i == ADDR_CONTROL_C_REG;
  wire hit_chan = paddr_i == ADDR_CHAN;
  wire hit_cmd = paddr_i == ADDR_CMD;
  wire hit_event_control_reg = paddr_i == ADDR_EVENT_CONTROL_REG;
  wire hit_irqen = paddr_i == ADDR_IRQEN;
  wire hit_flag = paddr_i == ADDR_IRQFLAG;
  wire hit_result = paddr_i == ADDR_RESULT;
  wire hit_winlt = paddr_i == ADDR_WINLT;
  wire hit_winht = paddr_i == ADDR_WINHT;
  wire hit_winctrl = paddr_i == ADDR_WINCTRL;
  wire hit_sdly = paddr_i == ADDR_SAMPDLY;
  wire hit_status = paddr_i == ADDR_STATUS;
  wire mapped = hit_control_a_reg || hit_control_b_reg || hit_control_c_reg || hit_chan || hit_cmd || hit_event_control_reg ||
                hit_irqen || hit_flag || hit_result || hit_winlt || hit_winht ||
                hit_winctrl || hit_sdly || hit_status;
  wire busy = state_q != ST_IDLE;
  wire tick;
  // Event synchroniser, edge taken past the second stage only
  wire ev_trig = ev_s2_q && !ev_s3_q && evin_q && enable; // RL9 RL10
  wire cmd_set = ev_trig || (wr && hit_cmd && pwdata_i[0] && enable);
  wire start_go = (state_q == ST_IDLE) && cmd_q && enable;
  wire conv_start = (state_q == ST_GAP) && tick && (gap_q == 5'h00);
  wire conv_done = (state_q == ST_CONV) && tick && (cyc_q == CONV_CYCLES - 4'h1); // RL14
  wire [2:0] acc_sel = (accsel_q > MAX_ACC_SEL) ? MAX_ACC_SEL : accsel_q;
  wire [6:0] last_smp = (7'h01 << acc_sel) - 7'h01; // RL17
  wire last_sample = smp_q == last_smp;
  wire [RES_W-1:0] sum = acc_q + {{(RES_W-DATA_W){1'b0}}, adc_data_i}; // RL3 RL22
  wire burst_done = conv_done && last_sample; // RL6
  wire win_hit = win_check(winmode_q, sum, winlt_q, winht_q); // RL23
  wire unlock = (state_q != ST_CONV) || (cyc_q == CONV_CYCLES - 4'h1);
  wire [4:0] rnd = sdly_auto_q ? {1'b0, lfsr_q[3:0]} : 5'h00;
  wire flag_w1c = wr && hit_flag;
  wire res_read = rd && hit_result;
  wire restart = free_running_sel && cmd_d; // RL11 RL20
  wire [31:0] rdata_mux =
    hit_control_a_reg ? {30'h0, control_a_reg_q} :
    hit_control_b_reg ? {29'h0, accsel_q} :
    hit_control_c_reg ? {26'h0, ref_q, 1'b0, clock_divider_sel_q} :
    hit_chan ? {27'h0, chan_q} :
    hit_cmd ? {31'h0, cmd_q} : // RL4
    hit_event_control_reg ? {31'h0, evin_q} :
    hit_irqen ? {30'h0, irqen_q} :
    hit_flag ? {30'h0, flag_q} :
    hit_result ? {16'h0, result_q} :
    hit_winlt ? {16'h0, winlt_q} :
    hit_winht ? {16'h0, winht_q} :
    hit_winctrl ? {29'h0, winmode_q} :
    hit_sdly ? {27'h0, sdly_auto_q, sdly_q} :
    hit_status ? {24'h0, reference_o, channel_o, busy} : 32'h0;

  acs_prescaler u_clock_divider_sel (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .run_i(enable && busy), // RL12 RL13
    .div_sel_i(clock_divider_sel_q),
    .tick_o(tick),
    .adc_clk_o(adc_clk_o)
  );

  // Start bit: set wins over the hardware clear
  always_comb
  begin
    cmd_d = cmd_q;
    if (wr && hit_cmd && !pwdata_i[0])
      cmd_d = 1'b0;
    if (burst_done && !free_running_sel)
      cmd_d = 1'b0; // RL4
    if (cmd_set)
      cmd_d = 1'b1; // RL10
    if (!enable)
      cmd_d = 1'b0; // RL1
  end

  // Flags: a completion in the same cycle as a clear is kept
  always_comb
  begin
    flag_d = flag_q;
    if (flag_w1c)
      flag_d = flag_q & ~pwdata_i[1:0]; // RL16
    if (res_read)
      flag_d[RDY_BIT] = 1'b0; // RL16
    if (burst_done)
    begin
      flag_d[RDY_BIT] = 1'b1; // RL6 RL8
      flag_d[WIN_BIT] = flag_d[WIN_BIT] || win_hit; // RL19
    end
  end

  always_comb
  begin
    state_d = state_q;
    gap_d = gap_q;
    case (state_q)
      ST_IDLE:
        if (start_go)
        begin
          state_d = ST_GAP;
          gap_d = 5'h00;
        end
      ST_GAP:
        if (tick)
        begin
          if (gap_q == 5'h00)
            state_d = ST_CONV;
          else
            gap_d = gap_q - 5'h01;
        end
      ST_CONV:
        if (conv_done)
        begin
          if (!last_sample)
          begin
            state_d = ST_GAP;
            gap_d = {1'b0, sdly_q} + rnd; // RL18
          end
          else if (restart)
          begin
            state_d = ST_GAP;
            gap_d = 5'h00;
          end
          else
            state_d = ST_IDLE;
        end
      default: state_d = ST_IDLE;
    endcase
    if (!enable)
      state_d = ST_IDLE; // RL1
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      pready_q <= 1'b0;
      prdata_o <= 32'h0;
      pslverr_o <= 1'b0;
    end
    else
    begin
      // One wait state so read data leaves a flop
      pready_q <= psel_i && penable_i && !pready_q;
      prdata_o <= (psel_i && penable_i && !pready_q && !pwrite_i) ? rdata_mux : 32'h0;
      pslverr_o <= psel_i && penable_i && !pready_q && !mapped;
    end
  end
  assign pready_o = pready_q;

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      control_a_reg_q <= 2'h0;
      accsel_q <= 3'h0;
      clock_divider_sel_q <= 3'h0;
      ref_q <= '0;
      chan_q <= '0;
      evin_q <= 1'b0;
      irqen_q <= 2'h0;
      winlt_q <= '0;
      winht_q <= '0;
      winmode_q <= WIN_NONE;
      sdly_q <= 4'h0;
      sdly_auto_q <= 1'b0;
    end
    else if (wr)
    begin
      if (hit_control_a_reg)
        control_a_reg_q <= pwdata_i[1:0];
      if (hit_control_b_reg)
        accsel_q <= pwdata_i[2:0];
      if (hit_control_c_reg)
      begin
        clock_divider_sel_q <= pwdata_i[2:0];
        ref_q <= pwdata_i[REF_LSB +: REF_W];
      end
      if (hit_chan)
        chan_q <= pwdata_i[CHAN_W-1:0];
      if (hit_event_control_reg)
        evin_q <= pwdata_i[0];
      if (hit_irqen)
        irqen_q <= pwdata_i[1:0];
      if (hit_winlt)
        winlt_q <= pwdata_i[RES_W-1:0];
      if (hit_winht)
        winht_q <= pwdata_i[RES_W-1:0];
      if (hit_winctrl)
        winmode_q <= pwdata_i[2:0];
      if (hit_sdly)
      begin
        sdly_q <= pwdata_i[3:0];
        sdly_auto_q <= pwdata_i[AUTO_BIT];
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      state_q <= ST_IDLE;
      cmd_q <= 1'b0;
      flag_q <= 2'h0;
      gap_q <= 5'h00;
      ev_s1_q <= 1'b0;
      ev_s2_q <= 1'b0;
      ev_s3_q <= 1'b0;
      irq_o <= 1'b0;
      conv_busy_o <= 1'b0;
      lfsr_q <= LFSR_SEED;
    end
    else
    begin
      state_q <= state_d;
      cmd_q <= cmd_d;
      flag_q <= flag_d;
      gap_q <= gap_d;
      ev_s1_q <= event_i;
      ev_s2_q <= ev_s1_q;
      ev_s3_q <= ev_s2_q;
      irq_o <= (flag_q[RDY_BIT] && irqen_q[RDY_BIT]) ||
               (flag_q[WIN_BIT] && irqen_q[WIN_BIT] && (winmode_q != WIN_NONE)); // RL7 RL19
      conv_busy_o <= state_d != ST_IDLE;
      if (conv_done)
        lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]}; // RL18
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      cyc_q <= 4'h0;
      smp_q <= 7'h00;
      acc_q <= '0;
      result_q <= '0;
      sample_o <= 1'b0;
      channel_o <= '0;
      reference_o <= '0;
    end
    else
    begin
      if (conv_start)
        cyc_q <= 4'h0;
      else if ((state_q == ST_CONV) && tick)
        cyc_q <= cyc_q + 4'h1;
      // Sample pulse on the second converter edge after start
      sample_o <= (state_q == ST_CONV) && tick && (cyc_q == SAMPLE_CYCLE - 4'h1); // RL15
      if (start_go)
      begin
        smp_q <= 7'h00;
        acc_q <= '0;
      end
      else if (conv_done)
      begin
        smp_q <= last_sample ? 7'h00 : smp_q + 7'h01;
        acc_q <= last_sample ? '0 : sum; // RL17
      end
      if (burst_done)
        result_q <= sum; // RL22
      // Selections track software only when enabled and outside the lock
      if (enable && unlock)
      begin
        channel_o <= chan_q; // RL2 RL5 RL21
        reference_o <= ref_q; // RL2 RL21
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  logic [3:0] hlp_ticks_q;
  always_ff @(posedge clk_i)
  begin
    if (srst_i || conv_start)
      hlp_ticks_q <= 4'h0;
    else if ((state_q == ST_CONV) && tick && (hlp_ticks_q != 4'hF))
      hlp_ticks_q <= hlp_ticks_q + 4'h1;
  end

  a_disable_stops: assert property (!enable |=> state_q == ST_IDLE && !cmd_q) // RL1
    else $error("converter still active while disabled");
  a_chan_locked: assert property ((state_q == ST_CONV) && $past(state_q) == ST_CONV &&
      $past(cyc_q) < CONV_CYCLES - 4'h1 |-> $stable(channel_o) && $stable(reference_o)) // RL5
    else $error("selection changed inside conversion");
  a_sample_point: assert property (sample_o |-> cyc_q == SAMPLE_CYCLE) // RL15
    else $error("sample pulse at wrong converter cycle");
  a_conv_length: assert property (conv_done |-> hlp_ticks_q == CONV_CYCLES - 4'h1) // RL14
    else $error("conversion length not thirteen converter cycles");
  a_flag_on_done: assert property (burst_done |=> flag_q[RDY_BIT]) // RL6
    else $error("result ready not set on completion");
  a_irq_gated: assert property ((irqen_q == 2'h0) [*2] |-> !irq_o) // RL7
    else $error("interrupt raised with enables clear");
  a_single_clear: assert property (burst_done && !free_running_sel && !cmd_set && enable |=> !cmd_q) // RL4
    else $error("start bit not cleared after single conversion");
  a_event_sets: assert property (ev_trig |=> cmd_q) // RL10
    else $error("event did not set start bit");
  a_idle_no_tick: assert property ((state_q == ST_IDLE) [*2] |-> !tick && !adc_clk_o) // RL13
    else $error("prescaler running while idle");
  a_read_clears: assert property (res_read && !burst_done |=> !flag_q[RDY_BIT]) // RL16
    else $error("result read did not clear flag");
  a_result_sum: assert property (burst_done |=> result_q == $past(sum)) // RL22
    else $error("result not loaded with final sum");
  a_free_running_sel_next: assert property (burst_done && free_running_sel && cmd_d && enable |=>
      state_q == ST_GAP && gap_q == 5'h00) // RL11
    else $error("free-running did not restart");

  c_free_running_sel: cover property (burst_done && free_running_sel ##[1:1000] burst_done);
  c_burst: cover property (burst_done && accsel_q != 3'h0);
  c_event: cover property (ev_trig && !cmd_q);
  c_window: cover property (burst_done && win_hit);
endmodule // acs_sequencer

// ### dv/acs_far_model.sv
// Far-side model: converter core holding the sampled input, and an event source
`timescale 1ns/1ps
module acs_far_model
  import acs_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic sample_i,
  input wire logic [CHAN_W-1:0] channel_i,
  output logic event_o,
  output logic [DATA_W-1:0] adc_data_o
);
  initial event_o = 1'b0;
  initial adc_data_o = '0;
  // Value depends on channel, so a late channel switch shows in the result
  always @(posedge clk_i)
  begin
    if (srst_i)
      adc_data_o <= '0;
    else if (sample_i === 1'b1)
      adc_data_o <= {5'h10, channel_i};
  end
  // Held four clocks so the input synchronizer cannot miss it
  task automatic fire_event();
  begin
    @(posedge clk_i);
    event_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    event_o <= 1'b0;
  end
  endtask
endmodule // acs_far_model

// ### dv/tb.sv
// Register-level testbench for the conversion sequencer
`timescale 1ns/1ps
module tb;
  import acs_pkg::*;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, event_i, adc_clk_o, sample_o, conv_busy_o, irq_o;
  logic [DATA_W-1:0] adc_data_i;
  logic [CHAN_W-1:0] channel_o;
  logic [REF_W-1:0] reference_o;
  int n_fail = 0;
  int n_compared = 0;
  int n_samp = 0;
  int k;
  logic [31:0] rdata;
  logic slverr;
  logic [2:0] acc_sel [2] = '{3'h2, 3'h7};
  int acc_n [2] = '{4, 64};
  logic win_exp [4] = '{1'b1, 1'b0, 1'b0, 1'b1};

  always #20 clk_i = ~clk_i;

  acs_sequencer DUT (.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .event_i(event_i), .adc_data_i(adc_data_i),
    .adc_clk_o(adc_clk_o), .sample_o(sample_o), .channel_o(channel_o),
    .reference_o(reference_o), .conv_busy_o(conv_busy_o), .irq_o(irq_o));

  acs_far_model u_far (.clk_i(clk_i), .srst_i(srst_i), .sample_i(sample_o),
    .channel_i(channel_o), .event_o(event_i), .adc_data_o(adc_data_i));

  always @(posedge clk_i)
  begin
    if (sample_o === 1'b1)
      n_samp <= n_samp + 1;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
  begin
    n_compared++;
    if (got !== exp)
    begin
      $display("mismatch at %0t: got %08h expected %08h", $time, got, exp);
      n_fail++;
    end
  end
  endtask

  // Request held until pready is seen high; no fixed wait assumed
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
  begin
    n = 0;
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (pready_o !== 1'b1 && n < 50);
    if (n >= 50)
      n_fail++;
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
  begin
    apb(1'b1, a, d, rd, err);
  end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic err;
  begin
    apb(1'b0, a, 32'h0, rd, err);
    check(rd, exp);
  end
  endtask

  task automatic start();
  begin
    wr(ADDR_CMD, 32'h1);
    repeat (2) @(posedge clk_i);
  end
  endtask

  task automatic wait_idle();
    int n;
  begin
    n = 0;
    while (conv_busy_o !== 1'b0 && n < 20000)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 20000)
      n_fail++;
    repeat (2) @(posedge clk_i);
  end
  endtask

  task automatic wait_samples(input int m);
    int n;
  begin
    n = 0;
    while (n_samp - k < m && n < 5000)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 5000)
      n_fail++;
  end
  endtask

  task automatic final_report();
  begin
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask

  // Longest path is the 64-sample burst, well under this span
  initial
  begin
    repeat (60000) @(posedge clk_i);
    n_fail++;
    final_report();
  end

  initial
  begin
    repeat (12) @(posedge clk_i);
    srst_i <= 1'b0;
    rd_chk(ADDR_CONTROL_A_REG, 32'h0);
    rd_chk(ADDR_STATUS, 32'h0);
    apb(1'b0, 8'h3C, 32'h0, rdata, slverr);
    check({31'h0, slverr}, 32'h1);
    check(rdata, 32'h0);
    wr(ADDR_CONTROL_C_REG, 32'h23);
    wr(ADDR_CHAN, 32'h5);
    wr(ADDR_CMD, 32'h1);
    repeat (4) @(posedge clk_i);
    check({31'h0, conv_busy_o}, 32'h0);
    check({27'h0, channel_o}, 32'h0);
    check({30'h0, reference_o}, 32'h0);
    wr(ADDR_CONTROL_A_REG, 32'h1);
    repeat (2) @(posedge clk_i);
    check({27'h0, channel_o}, 32'h5);
    check({30'h0, reference_o}, 32'h2);
    $display("test enable done");
    // Single conversion with a channel change while busy
    wr(ADDR_CHAN, 32'h3);
    start();
    rd_chk(ADDR_CMD, 32'h1);
    wr(ADDR_CHAN, 32'h7);
    k = n_samp;
    wait_samples(1);
    check({27'h0, channel_o}, 32'h3);
    wait_idle();
    rd_chk(ADDR_IRQFLAG, 32'h1);
    check({31'h0, irq_o}, 32'h0);
    rd_chk(ADDR_CMD, 32'h0);
    check({27'h0, channel_o}, 32'h7);
    wr(ADDR_IRQEN, 32'h1);
    repeat (2) @(posedge clk_i);
    check({31'h0, irq_o}, 32'h1);
    rd_chk(ADDR_RESULT, 32'h203);
    repeat (2) @(posedge clk_i);
    check({31'h0, irq_o}, 32'h0);
    $display("test single done");
    // Window modes below, above, inside, outside against a 0x207 result
    wr(ADDR_WINLT, 32'h300);
    wr(ADDR_WINHT, 32'h3F0);
    wr(ADDR_IRQEN, 32'h2);
    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_WINCTRL, 32'(i + 1));
      start();
      wait_idle();
      check({31'h0, irq_o}, {31'h0, win_exp[i]});
      rd_chk(ADDR_IRQFLAG, {30'h0, win_exp[i], 1'b1});
      wr(ADDR_IRQFLAG, 32'h1);
      rd_chk(ADDR_IRQFLAG, {30'h0, win_exp[i], 1'b0});
      wr(ADDR_IRQFLAG, 32'h2);
    end
    wr(ADDR_WINCTRL, 32'h0);
    $display("test window done");
    // Accumulation, four samples and the 64-sample ceiling
    for (int i = 0; i < 2; i++)
    begin
      wr(ADDR_CONTROL_B_REG, {29'h0, acc_sel[i]});
      wr(ADDR_SAMPDLY, (i == 0) ? 32'h13 : 32'h0);
      k = n_samp;
      start();
      wait_idle();
      check(32'(n_samp - k), 32'(acc_n[i]));
      rd_chk(ADDR_RESULT, 32'(acc_n[i] * 32'h207));
    end
    wr(ADDR_CONTROL_B_REG, 32'h0);
    $display("test accumulate done");
    // Event trigger, first with the input disabled
    u_far.fire_event();
    repeat (10) @(posedge clk_i);
    check({31'h0, conv_busy_o}, 32'h0);
    wr(ADDR_EVENT_CONTROL_REG, 32'h1);
    u_far.fire_event();
    repeat (2) @(posedge clk_i);
    check({31'h0, conv_busy_o}, 32'h1);
    wait_idle();
    rd_chk(ADDR_IRQFLAG, 32'h1);
    rd_chk(ADDR_CMD, 32'h0);
    wr(ADDR_IRQFLAG, 32'h1);
    $display("test event done");
    // Free-running until the start bit is cleared
    wr(ADDR_CONTROL_A_REG, 32'h3);
    k = n_samp;
    start();
    wait_samples(3);
    wr(ADDR_CMD, 32'h0);
    wait_idle();
    rd_chk(ADDR_IRQFLAG, 32'h1);
    k = n_samp;
    repeat (100) @(posedge clk_i);
    check(32'(n_samp - k), 32'h0);
    $display("test free_running_sel done");
    // Disable in mid-conversion aborts and stops the converter clock
    wr(ADDR_CONTROL_A_REG, 32'h1);
    start();
    repeat (20) @(posedge clk_i);
    wr(ADDR_CONTROL_A_REG, 32'h0);
    repeat (2) @(posedge clk_i);
    check({31'h0, conv_busy_o}, 32'h0);
    check({31'h0, adc_clk_o}, 32'h0);
    $display("test abort done");
    final_report();
  end
endmodule // tb
